//--- pkg/twu_pkg.sv
// constants for the tick, wakeup and watchdog unit
package twu_pkg;

   // ***********************************************************
   // special function register addresses
   // ***********************************************************
   localparam logic [7:0] ADDR_DATA_HIGH  = 8'hab;
   localparam logic [7:0] ADDR_DATA_LOW   = 8'hac;
   localparam logic [7:0] ADDR_CTRL       = 8'had;
   localparam logic [7:0] ADDR_TICK_DIV   = 8'hb5;
   localparam logic [7:0] ADDR_RESET_CAUSE = 8'hb1;
   localparam logic [7:0] ADDR_CLOCK_POWER = 8'hb6;

   // ***********************************************************
   // reset values and field positions
   // ***********************************************************
   localparam logic [7:0] TICK_DIV_RESET   = 8'h1d;
   localparam int         CTRL_BUSY_BIT    = 4;
   localparam int         CLK_STOP_BIT     = 1;
   localparam logic [7:0] RESET_CAUSE_INIT = 8'h02;

   // ***********************************************************
   // operation codes held in control bits 3:0
   // ***********************************************************
   localparam logic [3:0] OP_RD_WDOG    = 4'h0;
   localparam logic [3:0] OP_WR_WDOG    = 4'h8;
   localparam logic [3:0] OP_RD_LATCH   = 4'h2;
   localparam logic [3:0] OP_WR_LATCH   = 4'ha;
   localparam logic [3:0] OP_RD_COUNTER = 4'h3;
   localparam logic [3:0] OP_DISABLE    = 4'hb;

   // ***********************************************************
   // startup and shutdown lengths in oscillator cycles
   // ***********************************************************
   localparam logic [3:0] POR_START_CYC  = 4'he;
   localparam logic [3:0] WDOG_START_CYC = 4'hc;
   localparam logic [3:0] WAKE_START_CYC = 4'h3;
   localparam logic [3:0] SHUTDOWN_CYC   = 4'h2;

   // ***********************************************************
   // power sequencer states
   // ***********************************************************
   typedef enum logic [3:0]
   {
      PS_START = 4'b0001,
      PS_RUN   = 4'b0010,
      PS_SHUT  = 4'b0100,
      PS_DOWN  = 4'b1000
   } twu_pstate_t;

endpackage

//--- tb/tb_top.sv
// self-checking bench for the tick, wakeup and watchdog unit
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
   localparam int OSC_P = 6;
   localparam int TICK  = 2 * OSC_P;
   logic        clk, rst_n, osc, wr, rd, ext, clr;
   logic [7:0]  addr, wdata, rdata, v;
   logic        flag, cap, chip_rst, run, osc_run, cause;
   logic [15:0] d;
   int          miscompares, check_count, cyc, t1, t2, n;
   twu_osc_model #(.PERIOD(OSC_P)) u_osc (.clk_i(clk), .rst_n_i(rst_n), .edge_o(osc));
   twu_top dut
   (
      .SYS_CLK_I(clk), .RESET_N_I(rst_n), .OSC_EDGE_I(osc), .SFR_WR_I(wr),
      .SFR_RD_I(rd), .SFR_ADDR_I(addr), .SFR_WDATA_I(wdata), .EXT_IRQ_I(ext),
      .WAKE_IRQ_CLEAR_I(clr), .SFR_RDATA_O(rdata), .WAKE_IRQ_FLAG_O(flag),
      .TIMER_CAPTURE_O(cap), .CHIP_RESET_O(chip_rst), .CPU_RUN_O(run),
      .OSC_RUN_O(osc_run), .RESET_CAUSE_O(cause)
   );
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         miscompares++;
         final_report;
      end
   end
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] dt);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= dt;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] dt);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 dt = rdata;
   endtask
   task automatic wait_idle;
      v = 8'h10;
      for (int i = 0; i < 100 && v[4] !== 1'b0; i++)
         rd_reg(twu_pkg::ADDR_CTRL, v);
      `CHK(v[4], 1'b0)
   endtask
   // aligned to an oscillator pulse so busy is certain at the first poll
   task automatic op(input logic [3:0] c, input logic [15:0] dv);
      wait_idle;
      wr_reg(twu_pkg::ADDR_DATA_HIGH, dv[15:8]);
      wr_reg(twu_pkg::ADDR_DATA_LOW, dv[7:0]);
      @(posedge clk iff osc);
      wr_reg(twu_pkg::ADDR_CTRL, {4'h0, c});
      rd_reg(twu_pkg::ADDR_CTRL, v);
      `CHK(v[4:0], {1'b1, c})
      wait_idle;
      rd_reg(twu_pkg::ADDR_DATA_HIGH, d[15:8]);
      rd_reg(twu_pkg::ADDR_DATA_LOW, d[7:0]);
   endtask
   task automatic wait_flag(output int t);
      t = -1;
      for (int i = 0; i < 400 && t < 0; i++)
      begin
         @(posedge clk);
         #1 if (flag === 1'b1) t = cyc;
      end
   endtask
   task automatic clear_flag;
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
   endtask
   task automatic wait_run(output int e);
      e = 0;
      for (int i = 0; i < 400 && run !== 1'b1; i++)
      begin
         @(posedge clk);
         if (osc === 1'b1) e++;
      end
   endtask
   task automatic wait_low;
      for (int i = 0; i < 200 && run !== 1'b0; i++)
         @(posedge clk);
   endtask
   task automatic t_regs;
      logic [7:0] ra [5] = '{8'hab, 8'hac, 8'had, 8'hb5, 8'hc0};
      logic [7:0] re [5] = '{8'h00, 8'h00, 8'h00, 8'h1d, 8'h00};
      for (int i = 0; i < 5; i++)
      begin
         rd_reg(ra[i], v);
         `CHK(v, re[i])
      end
      `CHK(cause, 1'b0)
      wr_reg(twu_pkg::ADDR_TICK_DIV, 8'h01);
      repeat (20 * TICK) @(posedge clk);
      `CHK(flag, 1'b0)
   endtask
   task automatic t_wake(input logic [15:0] nv);
      op(twu_pkg::OP_WR_LATCH, nv);
      clear_flag;
      t1 = cyc;
      wait_flag(t2);
      `CHK((t2 - t1) >= (nv + 1) * TICK - 8 && (t2 - t1) <= (nv + 2) * TICK + 2, 1'b1)
      clear_flag;
      #1 `CHK(flag, 1'b0)
      wait_flag(t1);
      clear_flag;
      wait_flag(t2);
      `CHK(t2 - t1, (nv + 1) * TICK)
   endtask
   task automatic t_reads;
      op(twu_pkg::OP_RD_LATCH, 16'h0000);
      `CHK(d, 16'h0004)
      op(twu_pkg::OP_RD_COUNTER, 16'h0000);
      `CHK(d <= 16'h0004, 1'b1)
      op(twu_pkg::OP_WR_WDOG, 16'h0800);
      op(twu_pkg::OP_RD_WDOG, 16'h0000);
      `CHK(d >= 16'h07f0 && d <= 16'h0800, 1'b1)
      op(twu_pkg::OP_DISABLE, 16'h0000);
      clear_flag;
      repeat (8 * TICK) @(posedge clk);
      `CHK(flag, 1'b0)
   endtask
   task automatic t_pdown(input logic [7:0] c, input bit by_ext);
      if (!by_ext)
         op(twu_pkg::OP_WR_LATCH, 16'h0003);
      wait_idle;
      wr_reg(twu_pkg::ADDR_CLOCK_POWER, c);
      wait_low;
      `CHK(run, 1'b0)
      if (by_ext)
      begin
         repeat (10 * OSC_P) @(posedge clk);
         `CHK(run, 1'b0)
         ext <= 1'b1;
      end
      wait_run(n);
      ext <= 1'b0;
      `CHK(run, 1'b1)
      if (by_ext)
         `CHK(n >= 3 && n <= 4, 1'b1)
   endtask
   task automatic t_wdog;
      op(twu_pkg::OP_WR_WDOG, 16'h0003);
      wait_low;
      `CHK(run, 1'b0)
      wait_run(n);
      `CHK(n >= 12 && n <= 13, 1'b1)
      `CHK(cause, 1'b1)
      rd_reg(twu_pkg::ADDR_TICK_DIV, v);
      `CHK(v, twu_pkg::TICK_DIV_RESET)
      wr_reg(twu_pkg::ADDR_RESET_CAUSE, 8'h00);
      @(posedge clk);
      #1 `CHK(cause, 1'b0)
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      {rst_n, wr, rd, ext, clr} = 5'h00;
      {addr, wdata} = 16'h0000;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      wait_run(n);
      `CHK(n >= 14 && n <= 15, 1'b1)
      t_regs;
      t_wake(16'h0002);
      t_wake(16'h0004);
      t_reads;
      t_pdown(8'h02, 1'b1);
      t_pdown(8'h03, 1'b0);
      t_wdog;
      final_report;
   end
endmodule

//--- tb/twu_assertions.sv
// port-level checks for the tick, wakeup and watchdog unit
`timescale 1ns/10ps
module twu_assertions
(
   input wire logic       SYS_CLK_I,        // clock
   input wire logic       RESET_N_I,        // reset
   input wire logic       OSC_EDGE_I,       // osc pulse
   input wire logic       SFR_WR_I,         // write
   input wire logic       SFR_RD_I,         // read
   input wire logic [7:0] SFR_ADDR_I,       // address
   input wire logic [7:0] SFR_WDATA_I,      // wdata
   input wire logic       WAKE_IRQ_CLEAR_I, // clear
   input wire logic [7:0] SFR_RDATA_O,      // rdata
   input wire logic       WAKE_IRQ_FLAG_O,  // flag
   input wire logic       TIMER_CAPTURE_O,  // half rate
   input wire logic       CHIP_RESET_O,     // startup
   input wire logic       CPU_RUN_O,        // run
   input wire logic       OSC_RUN_O         // osc on
);
   logic [4:0] down_edges_ff;
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   // saturates so a long power-down cannot wrap into the legal window
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         down_edges_ff <= 5'h00;
      else if (CPU_RUN_O)
         down_edges_ff <= 5'h00;
      else if (OSC_EDGE_I && down_edges_ff != 5'h1f)
         down_edges_ff <= down_edges_ff + 5'h01;
   end
   sequence pd_req;
      SFR_WR_I && SFR_ADDR_I == twu_pkg::ADDR_CLOCK_POWER && SFR_WDATA_I[1] && CPU_RUN_O;
   endsequence
   sequence idle_run;
      !SFR_RD_I && CPU_RUN_O ##1 CPU_RUN_O;
   endsequence
   cap_toggle_a: assert property (CPU_RUN_O |=> $changed(TIMER_CAPTURE_O) == $past(OSC_EDGE_I, 2))
      else $error("capture level off half rate");
   unmapped_zero_a: assert property (SFR_RD_I && !(SFR_ADDR_I inside {8'hab, 8'hac, 8'had,
      8'hb5, 8'hb1, 8'hb6}) |=> SFR_RDATA_O == 8'h00)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (idle_run |-> $stable(SFR_RDATA_O))
      else $error("read data moved without read");
   osc_on_a: assert property (RESET_N_I |-> OSC_RUN_O)
      else $error("oscillator stopped");
   run_excl_a: assert property (CPU_RUN_O |-> !CHIP_RESET_O)
      else $error("cpu runs during chip reset");
   flag_sticky_a: assert property (WAKE_IRQ_FLAG_O && !WAKE_IRQ_CLEAR_I && CPU_RUN_O
      |=> WAKE_IRQ_FLAG_O || CHIP_RESET_O)
      else $error("wakeup flag lost");
   pd_stop_a: assert property (pd_req |=> ##1 !CPU_RUN_O [*8])
      else $error("power down not held");
   wake_edges_a: assert property ($rose(CPU_RUN_O) |-> down_edges_ff inside {[3:16]})
      else $error("restart edge count wrong");
endmodule
bind twu_top twu_assertions u_chk
(
   .SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .OSC_EDGE_I(OSC_EDGE_I),
   .SFR_WR_I(SFR_WR_I), .SFR_RD_I(SFR_RD_I), .SFR_ADDR_I(SFR_ADDR_I),
   .SFR_WDATA_I(SFR_WDATA_I), .WAKE_IRQ_CLEAR_I(WAKE_IRQ_CLEAR_I),
   .SFR_RDATA_O(SFR_RDATA_O), .WAKE_IRQ_FLAG_O(WAKE_IRQ_FLAG_O),
   .TIMER_CAPTURE_O(TIMER_CAPTURE_O), .CHIP_RESET_O(CHIP_RESET_O),
   .CPU_RUN_O(CPU_RUN_O), .OSC_RUN_O(OSC_RUN_O)
);

//--- tb/twu_osc_model.sv
// low-power oscillator: one-cycle pulse every PERIOD clocks
`timescale 1ns/10ps
module twu_osc_model
#(
   parameter int PERIOD = 6
)
(
   input  wire logic clk_i,   // system clock
   input  wire logic rst_n_i, // async reset
   output logic      edge_o   // period pulse
);
   int cnt_ff;
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_ff <= 0;
         edge_o <= 1'b0;
      end
      else
      begin
         cnt_ff <= (cnt_ff == PERIOD - 1) ? 0 : cnt_ff + 1;
         edge_o <= (cnt_ff == PERIOD - 1);
      end
   end
endmodule

//--- verilog/twu_down_counter.sv
// loadable 16-bit down counter stepped by the tick
`timescale 1ns/10ps
module twu_down_counter
#(
   parameter int W = 16
)
(
   input  wire logic         clk_i,   // system clock
   input  wire logic         rst_n_i, // async reset
   input  wire logic         run_i,   // counting allowed
   input  wire logic         step_i,  // tick pulse
   input  wire logic         load_i,  // load request
   input  wire logic [W-1:0] value_i, // load value
   output logic [W-1:0]      count_o, // current count
   output logic              zero_o   // pulse when a step finds zero
);

   logic skip_ff;

   // a step taken at zero reports and reloads, giving value+1 ticks per period;
   // the first step after a load is swallowed so the first report lands
   // value+1 to value+2 tick periods after the load, whatever the tick phase
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         count_o <= '0;
         zero_o  <= 1'b0;
         skip_ff <= 1'b0;
      end
      else
      begin
         zero_o <= 1'b0;
         if (load_i)
         begin
            count_o <= value_i;
            skip_ff <= 1'b1;                                            // RULE6
         end
         else if (run_i && step_i)
         begin
            if (skip_ff)
               skip_ff <= 1'b0;                                         // RULE6
            else if (count_o == '0)
            begin
               zero_o  <= 1'b1;
               count_o <= value_i;
            end
            else
            begin
               count_o <= count_o - 1'b1;
            end
         end
      end
   end

endmodule

//--- verilog/twu_tick_gen.sv
// tick divider and half-rate calibration signal from the oscillator edge
`timescale 1ns/10ps
module twu_tick_gen
#(
   parameter int W = 8
)
(
   input  wire logic         clk_i,      // system clock
   input  wire logic         rst_n_i,    // async reset
   input  wire logic         osc_edge_i, // one pulse per oscillator period
   input  wire logic [W-1:0] div_i,      // divider setting
   output logic              tick_o,     // one-cycle tick pulse
   output logic              half_o      // half oscillator rate level
);

   logic [W-1:0] cnt_ff;

   // tick every div+1 oscillator periods
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_ff <= '0;
         tick_o <= 1'b0;
      end
      else
      begin
         tick_o <= 1'b0;
         if (osc_edge_i)
         begin
            if (cnt_ff >= div_i)
            begin
               cnt_ff <= '0;
               tick_o <= 1'b1;                                          // RULE1
            end
            else
            begin
               cnt_ff <= cnt_ff + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         half_o <= 1'b0;
      else if (osc_edge_i)
         half_o <= ~half_o;                                             // RULE2
   end

endmodule

//--- verilog/twu_top.sv
// tick, wakeup timer, watchdog and power sequencer behind cpu registers
// Behaviour
// RULE1: tick equals oscillator divided by divider plus one
// RULE2: timer capture gets half oscillator rate
// RULE3: wakeup down counter interrupts and auto-reloads
// RULE4: wakeup disabled until first latch write
// RULE5: every latch write reloads the counter
// RULE6: first wakeup N+1 to N+2 ticks
// RULE7: each wakeup sets interrupt flag
// RULE8: wakeup restarts stopped oscillator regardless of enable
// RULE9: watchdog starts on first control write
// RULE10: code 1000 loads watchdog from data
// RULE11: watchdog counts ticks, zero resets chip
// RULE12: code 1010 writes latch, 1011 disables
// RULE13: read codes fetch watchdog, latch, counter
// RULE14: busy in bit 4, opcode bits 3:0
// RULE15: software writes data bytes then control
// RULE16: software reads after busy clears
// RULE17: software waits not busy before power register
// RULE18: 0x2 or 0x3 starts controlled shutdown
// RULE19: restart 3-4 cycles, shutdown 2-3 cycles
// RULE20: power-on startup about 14 oscillator cycles
// RULE21: watchdog startup 12 oscillator cycles
// RULE22: reset cause bit zero for power-on only
// RULE23: busy held until slow side completes
`timescale 1ns/10ps
module twu_top
#(
   parameter int DW = 16
)
(
   input  wire logic       SYS_CLK_I,           // system clock, 250 MHz
   input  wire logic       RESET_N_I,           // power-on reset, active low
   input  wire logic       OSC_EDGE_I,          // one pulse per oscillator period
   input  wire logic       SFR_WR_I,            // register write strobe
   input  wire logic       SFR_RD_I,            // register read strobe
   input  wire logic [7:0] SFR_ADDR_I,          // register address
   input  wire logic [7:0] SFR_WDATA_I,         // write data
   input  wire logic       EXT_IRQ_I,           // external interrupt wake request
   input  wire logic       WAKE_IRQ_CLEAR_I,    // cpu clears wakeup flag
   output logic [7:0]      SFR_RDATA_O,         // read data
   output logic            WAKE_IRQ_FLAG_O,     // wakeup interrupt flag
   output logic            TIMER_CAPTURE_O,     // half oscillator rate
   output logic            CHIP_RESET_O,        // chip held in reset, or in startup while reset cause bit 1 is clear
   output logic            CPU_RUN_O,           // cpu clock and power available
   output logic            OSC_RUN_O,           // oscillator and regulators on
   output logic            RESET_CAUSE_O        // 0 after power-on, 1 otherwise
);

   // ***********************************************************
   // registers
   // ***********************************************************
   logic [7:0]  data_high_ff;
   logic [7:0]  data_low_ff;
   logic [3:0]  opcode_ff;
   logic        busy_ff;
   logic        go_ff;
   logic [7:0]  tick_div_ff;
   logic [1:0]  reset_cause_ff;
   logic [1:0]  clock_power_ff;
   logic [DW-1:0] latch_ff;
   logic        wake_en_ff;
   logic        wdog_on_ff;
   logic        wdog_fire_ff;
   logic [3:0]  seq_cnt_ff;
   twu_pkg::twu_pstate_t pstate_ff;

   logic        tick;
   logic        half;
   logic [DW-1:0] wake_cnt;
   logic [DW-1:0] wdog_cnt;
   logic        wake_zero;
   logic        wdog_zero;
   logic        wr_ctrl;
   logic        do_op;
   logic        ld_wake;
   logic        ld_wdog;
   logic        wr_clk;
   logic        osc_step;

   assign wr_ctrl = SFR_WR_I && (SFR_ADDR_I == twu_pkg::ADDR_CTRL);
   assign wr_clk  = SFR_WR_I && (SFR_ADDR_I == twu_pkg::ADDR_CLOCK_POWER);
   // operation executes on an oscillator edge, modelling the slow-side handshake
   assign do_op   = busy_ff && go_ff && OSC_EDGE_I;
   assign ld_wake = do_op && (opcode_ff == twu_pkg::OP_WR_LATCH);
   assign ld_wdog = do_op && (opcode_ff == twu_pkg::OP_WR_WDOG);
   // the tick divider steps only while the oscillator runs; the sequencer and do_op use OSC_EDGE_I directly
   assign osc_step = OSC_EDGE_I && OSC_RUN_O;

   // ***********************************************************
   // tick generation and counters
   // ***********************************************************
   twu_tick_gen #(.W(8)) u_tick
   (
      .clk_i      (SYS_CLK_I),
      .rst_n_i    (RESET_N_I),
      .osc_edge_i (osc_step),
      .div_i      (tick_div_ff),
      .tick_o     (tick),
      .half_o     (half)
   );

   twu_down_counter #(.W(DW)) u_wake
   (
      .clk_i   (SYS_CLK_I),
      .rst_n_i (RESET_N_I),
      .run_i   (wake_en_ff),
      .step_i  (tick),
      .load_i  (ld_wake),                                               // RULE5
      .value_i (ld_wake ? {data_high_ff, data_low_ff} : latch_ff),
      .count_o (wake_cnt),
      .zero_o  (wake_zero)                                              // RULE3 RULE6
   );

   twu_down_counter #(.W(DW)) u_wdog
   (
      .clk_i   (SYS_CLK_I),
      .rst_n_i (RESET_N_I),
      .run_i   (wdog_on_ff && !CHIP_RESET_O),
      .step_i  (tick),                                                  // RULE11
      .load_i  (ld_wdog || CHIP_RESET_O),                               // RULE10
      .value_i (ld_wdog ? {data_high_ff, data_low_ff} : '1),
      .count_o (wdog_cnt),
      .zero_o  (wdog_zero)
   );

   // ***********************************************************
   // register interface
   // ***********************************************************
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         data_high_ff <= 8'h00;
         data_low_ff  <= 8'h00;
      end
      else if (CHIP_RESET_O)
      begin
         data_high_ff <= 8'h00;
         data_low_ff  <= 8'h00;
      end
      else if (do_op && (opcode_ff == twu_pkg::OP_RD_WDOG))
         {data_high_ff, data_low_ff} <= wdog_cnt;                       // RULE13
      else if (do_op && (opcode_ff == twu_pkg::OP_RD_LATCH))
         {data_high_ff, data_low_ff} <= latch_ff;                       // RULE13
      else if (do_op && (opcode_ff == twu_pkg::OP_RD_COUNTER))
         {data_high_ff, data_low_ff} <= wake_cnt;                       // RULE13
      else if (SFR_WR_I && (SFR_ADDR_I == twu_pkg::ADDR_DATA_HIGH))
         data_high_ff <= SFR_WDATA_I;
      else if (SFR_WR_I && (SFR_ADDR_I == twu_pkg::ADDR_DATA_LOW))
         data_low_ff <= SFR_WDATA_I;
   end

   // busy rises on the control write and holds until the slow edge completes it
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         opcode_ff <= 4'h0;
         busy_ff   <= 1'b0;
         go_ff     <= 1'b0;
      end
      else if (CHIP_RESET_O)
      begin
         opcode_ff <= 4'h0;
         busy_ff   <= 1'b0;
         go_ff     <= 1'b0;
      end
      else if (wr_ctrl && !busy_ff)
      begin
         opcode_ff <= SFR_WDATA_I[3:0];                                 // RULE14
         busy_ff   <= 1'b1;                                             // RULE23
         go_ff     <= 1'b0;
      end
      else if (do_op)
         busy_ff <= 1'b0;                                               // RULE23
      else
         go_ff <= busy_ff;
   end

   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         tick_div_ff <= twu_pkg::TICK_DIV_RESET;                        // RULE1
      else if (CHIP_RESET_O)
         tick_div_ff <= twu_pkg::TICK_DIV_RESET;
      else if (SFR_WR_I && (SFR_ADDR_I == twu_pkg::ADDR_TICK_DIV))
         tick_div_ff <= SFR_WDATA_I;
   end

   // ***********************************************************
   // wakeup latch and enable
   // ***********************************************************
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         latch_ff   <= '0;
         wake_en_ff <= 1'b0;                                            // RULE4
      end
      else if (CHIP_RESET_O)
      begin
         latch_ff   <= '0;
         wake_en_ff <= 1'b0;
      end
      else if (ld_wake)
      begin
         latch_ff   <= {data_high_ff, data_low_ff};                     // RULE12
         wake_en_ff <= 1'b1;                                            // RULE4
      end
      else if (do_op && (opcode_ff == twu_pkg::OP_DISABLE))
         wake_en_ff <= 1'b0;                                            // RULE12
   end

   // set wins over clear
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         WAKE_IRQ_FLAG_O <= 1'b0;
      else if (wake_zero)
         WAKE_IRQ_FLAG_O <= 1'b1;                                       // RULE7
      else if (WAKE_IRQ_CLEAR_I || CHIP_RESET_O)
         WAKE_IRQ_FLAG_O <= 1'b0;
   end

   // ***********************************************************
   // watchdog activation and reset cause
   // ***********************************************************
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         wdog_on_ff   <= 1'b0;
         wdog_fire_ff <= 1'b0;
      end
      else if (CHIP_RESET_O)
      begin
         wdog_on_ff   <= 1'b0;
         wdog_fire_ff <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
            wdog_on_ff <= 1'b1;                                         // RULE9
         if (wdog_zero)
            wdog_fire_ff <= 1'b1;                                       // RULE11
      end
   end

   // cause survives the watchdog startup; cpu may clear it
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         reset_cause_ff <= twu_pkg::RESET_CAUSE_INIT[1:0];              // RULE22
      else if (wdog_fire_ff)
         reset_cause_ff[0] <= 1'b1;                                     // RULE22
      else if (SFR_WR_I && (SFR_ADDR_I == twu_pkg::ADDR_RESET_CAUSE) && !CHIP_RESET_O)
         reset_cause_ff <= SFR_WDATA_I[1:0];
   end

   // ***********************************************************
   // power sequencer
   // ***********************************************************
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         pstate_ff      <= twu_pkg::PS_START;
         seq_cnt_ff     <= twu_pkg::POR_START_CYC;                      // RULE20
         clock_power_ff <= 2'b00;
      end
      else if (wdog_fire_ff)
      begin
         pstate_ff      <= twu_pkg::PS_START;
         seq_cnt_ff     <= twu_pkg::WDOG_START_CYC;                     // RULE21
         clock_power_ff <= 2'b00;
      end
      else
      begin
         unique case (pstate_ff)
            twu_pkg::PS_START:
            begin
               if (seq_cnt_ff == 4'h0)
                  pstate_ff <= twu_pkg::PS_RUN;
               else if (OSC_EDGE_I)
                  seq_cnt_ff <= seq_cnt_ff - 4'h1;
            end
            twu_pkg::PS_RUN:
            begin
               if (wr_clk && SFR_WDATA_I[twu_pkg::CLK_STOP_BIT])
               begin
                  clock_power_ff <= SFR_WDATA_I[1:0];                   // RULE18
                  pstate_ff      <= twu_pkg::PS_SHUT;
                  seq_cnt_ff     <= twu_pkg::SHUTDOWN_CYC;              // RULE19
               end
               else if (wr_clk)
                  clock_power_ff <= SFR_WDATA_I[1:0];
            end
            twu_pkg::PS_SHUT:
            begin
               if (seq_cnt_ff == 4'h0)
                  pstate_ff <= twu_pkg::PS_DOWN;
               else if (OSC_EDGE_I)
                  seq_cnt_ff <= seq_cnt_ff - 4'h1;
            end
            twu_pkg::PS_DOWN:
            begin
               // wake ignores the interrupt enable
               if (EXT_IRQ_I || wake_zero)                              // RULE8 RULE18
               begin
                  pstate_ff      <= twu_pkg::PS_START;
                  seq_cnt_ff     <= twu_pkg::WAKE_START_CYC;            // RULE19
                  clock_power_ff <= 2'b00;
               end
            end
            default:
            begin
               pstate_ff  <= twu_pkg::PS_START;
               seq_cnt_ff <= twu_pkg::POR_START_CYC;
            end
         endcase
      end
   end

   // ***********************************************************
   // outputs
   // ***********************************************************
   // the wakeup counter keeps the oscillator ticking while powered down,
   // so osc_run is held high in every sequencer state, power-down included
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         CHIP_RESET_O    <= 1'b1;
         CPU_RUN_O       <= 1'b0;
         OSC_RUN_O       <= 1'b1;
         TIMER_CAPTURE_O <= 1'b0;
         RESET_CAUSE_O   <= 1'b0;
      end
      else
      begin
         CHIP_RESET_O    <= wdog_fire_ff ||
                            (pstate_ff == twu_pkg::PS_START && !reset_cause_ff[1]);
         CPU_RUN_O       <= (pstate_ff == twu_pkg::PS_RUN) && !wdog_fire_ff;
         OSC_RUN_O       <= 1'b1;
         TIMER_CAPTURE_O <= half;                                       // RULE2
         RESET_CAUSE_O   <= reset_cause_ff[0];
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         SFR_RDATA_O <= 8'h00;
      else if (SFR_RD_I)
      begin
         unique case (SFR_ADDR_I)
            twu_pkg::ADDR_DATA_HIGH:   SFR_RDATA_O <= data_high_ff;
            twu_pkg::ADDR_DATA_LOW:    SFR_RDATA_O <= data_low_ff;
            twu_pkg::ADDR_CTRL:        SFR_RDATA_O <= {3'h0, busy_ff, opcode_ff}; // RULE14
            twu_pkg::ADDR_TICK_DIV:    SFR_RDATA_O <= tick_div_ff;
            twu_pkg::ADDR_RESET_CAUSE: SFR_RDATA_O <= {6'h00, reset_cause_ff};
            twu_pkg::ADDR_CLOCK_POWER: SFR_RDATA_O <= {6'h00, clock_power_ff};
            default:                   SFR_RDATA_O <= 8'h00;
         endcase
      end
   end

endmodule
